// ### design/rsvc_pkg.sv
// Constants, register map and encodings for the reference switchover and VCO calibration block
// Contract
// - Reset leaves switch mode revertive (00); primary preferred, return to primary when back.
// - Mode 01 nonrevertive: once on secondary, stay there until secondary fails.
// - Modes 10/11 manually pick primary/secondary, used only while that input is present.
// - Both references absent: holdover onto the crystal input if the crystal is present.
// - Holdover onto the crystal is suppressed in both manual modes.
// - Nothing present: wait, then select by switch mode and force-secondary pin.
// - Force-secondary pin picks secondary over primary choices, only while secondary present.
// - Three presence detectors sampled on PLL feedback, driving selection directly.
// - Differential receiver mode: secondary is complement, single reference, no switchover.
// - Six-bit crystal trim in 0.25 pF steps, 0 to 15.75 pF, over fixed 8 pF.
// - Reset default programmable crystal capacitance is 2 pF, 10 pF total.
// - Clearing tuning-source bit hands trim to field, whose all-ones default gives 15.75 pF.
// - VCO band and gain calibration runs automatically after every reset.
// - Forced calibration: set calibration enable, then write calibrate bit; starts on that write.
// - Output drivers hold a static level while calibration runs.
// - Band override: set band enable, then write seven-bit band number; 128 bands.
// - Feedback divider is a 20-bit integer; values below 32 are not used.
// - Each reference path has optional divide-by-five ahead of optional doubler.
// - Serial port only when either frequency-select group is all zero; else pins are output mode.
// - All register-control enable bits reset to 0, so pin decoders drive functions.
package rsvc_pkg;
	// Register offsets
	localparam logic [12:0] ADDR_VCO_CAL = 13'h000e;
	localparam logic [12:0] ADDR_VCO_BAND = 13'h0010;
	localparam logic [12:0] ADDR_CRYSTAL_OSC_INPUT_TRIM = 13'h001b;
	localparam logic [12:0] ADDR_FB_DIV_LO = 13'h0020;
	localparam logic [12:0] ADDR_FB_DIV_MID = 13'h0021;
	localparam logic [12:0] ADDR_FB_DIV_HI = 13'h0022;
	localparam logic [12:0] ADDR_SWITCH_MODE = 13'h0029;
	localparam logic [12:0] ADDR_REF_PATH = 13'h002a;
	localparam logic [12:0] ADDR_STATUS = 13'h002b;
	// Field positions
	localparam int CAL_CMD_BIT = 7;
	localparam int CAL_EN_BIT = 2;
	localparam int BAND_EN_BIT = 0;
	localparam int CRYSTAL_OSC_INPUT_SRC_BIT = 7;
	localparam int DIFF_BIT = 5;
	localparam int FB_EN_BIT = 4;
	// Reset values
	localparam logic [7:0] VCO_CAL_RST = 8'h00;
	localparam logic [7:0] VCO_BAND_RST = 8'h00;
	localparam logic [7:0] CRYSTAL_OSC_INPUT_TRIM_RST = 8'hbf;
	localparam logic [7:0] SWITCH_MODE_RST = 8'h00;
	localparam logic [7:0] REF_PATH_RST = 8'h00;
	localparam logic [19:0] FB_DIV_RST = 20'h0_0020;
	// Crystal trim: 2 pF at 0.25 pF per step
	localparam logic [5:0] CRYSTAL_OSC_INPUT_CAP_PIN_CODE = 6'h08;
	// Feedback divider floor
	localparam logic [19:0] FB_DIV_MIN = 20'h0_0020;
	// Switch modes
	localparam logic [1:0] MODE_REVERTIVE = 2'h0;
	localparam logic [1:0] MODE_NONREVERTIVE = 2'h1;
	localparam logic [1:0] MODE_MAN_PRIMARY = 2'h2;
	localparam logic [1:0] MODE_MAN_SECONDARY = 2'h3;
	// Selector states, one-hot
	typedef enum logic [3:0] {
		SEL_NONE = 4'h1,
		SEL_PRIMARY = 4'h2,
		SEL_SECONDARY = 4'h4,
		SEL_CRYSTAL = 4'h8
	} rsvc_sel_t;
	// Calibration states, one-hot
	typedef enum logic [1:0] {
		CAL_IDLE = 2'h1,
		CAL_RUN = 2'h2
	} rsvc_cal_t;
	// Timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int CAL_TIME_NS = 100000;
	localparam int CAL_CYCLES = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DET_TIMEOUT_SAMPLES = 8;
	// Serial frame layout
	localparam logic [4:0] SPI_INSTR_LAST = 5'h0f;
	localparam logic [4:0] SPI_DATA_FIRST = 5'h10;
	localparam logic [4:0] SPI_DATA_LAST = 5'h17;
	localparam logic [4:0] SPI_FRAME_END = 5'h18;
endpackage : rsvc_pkg

// ### design/rsvc_presence_det.sv
// Signal presence detector sampled on the PLL feedback enable
`timescale 1ns/1ps
module rsvc_presence_det #(
	parameter int TIMEOUT = rsvc_pkg::DET_TIMEOUT_SAMPLES
) (
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic i_sample_en,
	input wire logic i_sig,
	output logic o_present
);
	logic last;
	logic [7:0] idle_cnt;

	// Edge watch and idle count, advanced only on feedback samples
	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
		begin
			last <= 1'b0;
			idle_cnt <= 8'h00;
			o_present <= 1'b0;
		end
		else if (i_sample_en)
		begin
			last <= i_sig;
			if (last != i_sig)
			begin
				idle_cnt <= 8'h00;
				o_present <= 1'b1;
			end
			else if (idle_cnt >= 8'(TIMEOUT - 1))
				o_present <= 1'b0;
			else
				idle_cnt <= idle_cnt + 8'h01;
		end
	end
endmodule : rsvc_presence_det

// ### design/rsvc_spi.sv
// Three-wire serial port slave: 16-bit instruction, one data byte
`timescale 1ns/1ps
module rsvc_spi (
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic i_enable,
	input wire logic i_sclk,
	input wire logic i_csb,
	input wire logic i_sdio_in,
	input wire logic [7:0] i_rdata,
	output logic o_sdio_out,
	output logic o_sdio_oe,
	output logic [12:0] o_addr,
	output logic [7:0] o_wdata,
	output logic o_wr
);
	logic sclk_d;
	logic rd;
	logic [4:0] cnt;
	logic [14:0] shift;
	logic rise;
	logic fall;

	assign rise = i_sclk & ~sclk_d;
	assign fall = ~i_sclk & sclk_d;

	// Sclk history for edge detection
	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
			sclk_d <= 1'b0;
		else
			sclk_d <= i_sclk;
	end

	// Frame engine; chip select high or port disabled aborts the frame
	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst || i_csb || !i_enable)
		begin
			cnt <= 5'h00;
			shift <= 15'h0000;
			rd <= 1'b0;
			o_addr <= 13'h0000;
			o_wdata <= 8'h00;
			o_wr <= 1'b0;
			o_sdio_out <= 1'b0;
			o_sdio_oe <= 1'b0;
		end
		else
		begin
			o_wr <= 1'b0;
			if (rise && cnt < rsvc_pkg::SPI_FRAME_END)
			begin
				cnt <= cnt + 5'h01;
				shift <= {shift[13:0], i_sdio_in};
				if (cnt == rsvc_pkg::SPI_INSTR_LAST)
				begin
					rd <= shift[14];
					o_addr <= {shift[11:0], i_sdio_in};
				end
				if (cnt == rsvc_pkg::SPI_DATA_LAST && !rd)
				begin
					o_wdata <= {shift[6:0], i_sdio_in};
					o_wr <= 1'b1;
				end
			end
			// Read data leaves on falling edges, msb first
			if (fall && rd && cnt >= rsvc_pkg::SPI_DATA_FIRST && cnt <= rsvc_pkg::SPI_DATA_LAST)
			begin
				o_sdio_oe <= 1'b1;
				o_sdio_out <= i_rdata[3'(rsvc_pkg::SPI_DATA_LAST - cnt)];
			end
			else if (fall && cnt == rsvc_pkg::SPI_FRAME_END)
				o_sdio_oe <= 1'b0;
		end
	end
endmodule : rsvc_spi

// ### design/rsvc_top.sv
// Reference switchover, holdover, VCO calibration and register control
`timescale 1ns/1ps
module rsvc_top #(
	parameter int CAL_CYCLES = rsvc_pkg::CAL_CYCLES,
	parameter int DET_TIMEOUT = rsvc_pkg::DET_TIMEOUT_SAMPLES
) (
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic i_fb_sample_en,
	input wire logic i_primary_ref_input,
	input wire logic i_secondary_ref_input,
	input wire logic i_crystal_osc_input,
	input wire logic i_force_secondary_pin,
	input wire logic [3:0] i_freq_sel_a,
	input wire logic [5:0] i_freq_sel_y,
	input wire logic [19:0] i_pin_fb_div,
	input wire logic [6:0] i_auto_band,
	input wire logic i_sclk_om0,
	input wire logic i_csb_om1,
	input wire logic i_sdio_in_om2,
	output logic o_sdio_out,
	output logic o_sdio_oe,
	output logic [2:0] o_out_mode_pins,
	output logic [3:0] o_ref_select,
	output logic o_holdover,
	output logic o_diff_input,
	output logic o_cal_busy,
	output logic o_outputs_static,
	output logic [6:0] o_vco_band,
	output logic [5:0] o_crystal_osc_input_cap_code,
	output logic [19:0] o_fb_div,
	output logic o_div5_primary,
	output logic o_x2_primary,
	output logic o_div5_secondary,
	output logic o_x2_secondary
);
	logic spi_mode;
	logic pri_present;
	logic sec_present;
	logic crystal_osc_input_present;
	logic [12:0] bus_addr;
	logic [7:0] bus_wdata;
	logic bus_wr;
	logic [7:0] bus_rdata;
	logic [7:0] vco_calibration_control;
	logic [7:0] vco_band_override;
	logic [7:0] crystal_load_trim;
	logic [7:0] reference_switch_mode;
	logic [7:0] reference_path_control;
	logic [19:0] feedback_divider;
	logic [1:0] mode;
	logic diff_mode;
	logic cal_kick;
	logic [19:0] fb_src;
	logic [12:0] cal_cnt;
	rsvc_pkg::rsvc_sel_t sel;
	rsvc_pkg::rsvc_sel_t next_sel;
	rsvc_pkg::rsvc_cal_t cal;

	// Serial mode decoded from the frequency-select pin groups
	assign spi_mode = (i_freq_sel_a == 4'h0) || (i_freq_sel_y == 6'h00);
	assign mode = reference_switch_mode[7:6];
	assign diff_mode = reference_switch_mode[rsvc_pkg::DIFF_BIT];

	rsvc_spi u_spi (
		.i_ref_clk(i_ref_clk),
		.i_sys_rst(i_sys_rst),
		.i_enable(spi_mode),
		.i_sclk(i_sclk_om0),
		.i_csb(i_csb_om1),
		.i_sdio_in(i_sdio_in_om2),
		.i_rdata(bus_rdata),
		.o_sdio_out(o_sdio_out),
		.o_sdio_oe(o_sdio_oe),
		.o_addr(bus_addr),
		.o_wdata(bus_wdata),
		.o_wr(bus_wr)
	);

	// Shared pins feed the output-mode decoder when the port is off
	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
			o_out_mode_pins <= 3'h0;
		else if (!spi_mode)
			o_out_mode_pins <= {i_sdio_in_om2, i_csb_om1, i_sclk_om0};
	end

	// One detector per input, all sampled by the feedback enable
	rsvc_presence_det #(.TIMEOUT(DET_TIMEOUT)) u_det_pri (
		.i_ref_clk(i_ref_clk),
		.i_sys_rst(i_sys_rst),
		.i_sample_en(i_fb_sample_en),
		.i_sig(i_primary_ref_input),
		.o_present(pri_present)
	);
	rsvc_presence_det #(.TIMEOUT(DET_TIMEOUT)) u_det_sec (
		.i_ref_clk(i_ref_clk),
		.i_sys_rst(i_sys_rst),
		.i_sample_en(i_fb_sample_en),
		.i_sig(i_secondary_ref_input),
		.o_present(sec_present)
	);
	rsvc_presence_det #(.TIMEOUT(DET_TIMEOUT)) u_det_crystal_osc_input (
		.i_ref_clk(i_ref_clk),
		.i_sys_rst(i_sys_rst),
		.i_sample_en(i_fb_sample_en),
		.i_sig(i_crystal_osc_input),
		.o_present(crystal_osc_input_present)
	);

	// Register writes; every control enable resets to 0 so pins rule at start
	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
		begin
			vco_calibration_control <= rsvc_pkg::VCO_CAL_RST;
			vco_band_override <= rsvc_pkg::VCO_BAND_RST;
			crystal_load_trim <= rsvc_pkg::CRYSTAL_OSC_INPUT_TRIM_RST;
			reference_switch_mode <= rsvc_pkg::SWITCH_MODE_RST;
			reference_path_control <= rsvc_pkg::REF_PATH_RST;
			feedback_divider <= rsvc_pkg::FB_DIV_RST;
		end
		else if (bus_wr)
		begin
			case (bus_addr)
				// Calibrate command bit is not stored; it only triggers
				rsvc_pkg::ADDR_VCO_CAL: vco_calibration_control <= {1'b0, bus_wdata[6:0]};
				rsvc_pkg::ADDR_VCO_BAND: vco_band_override <= bus_wdata;
				rsvc_pkg::ADDR_CRYSTAL_OSC_INPUT_TRIM: crystal_load_trim <= bus_wdata;
				rsvc_pkg::ADDR_SWITCH_MODE: reference_switch_mode <= bus_wdata;
				rsvc_pkg::ADDR_REF_PATH: reference_path_control <= bus_wdata;
				rsvc_pkg::ADDR_FB_DIV_LO: feedback_divider[7:0] <= bus_wdata;
				rsvc_pkg::ADDR_FB_DIV_MID: feedback_divider[15:8] <= bus_wdata;
				rsvc_pkg::ADDR_FB_DIV_HI: feedback_divider[19:16] <= bus_wdata[3:0];
				default: ;
			endcase
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb
	begin
		case (bus_addr)
			rsvc_pkg::ADDR_VCO_CAL: bus_rdata = {o_cal_busy, vco_calibration_control[6:0]};
			rsvc_pkg::ADDR_VCO_BAND: bus_rdata = vco_band_override;
			rsvc_pkg::ADDR_CRYSTAL_OSC_INPUT_TRIM: bus_rdata = crystal_load_trim;
			rsvc_pkg::ADDR_SWITCH_MODE: bus_rdata = reference_switch_mode;
			rsvc_pkg::ADDR_REF_PATH: bus_rdata = reference_path_control;
			rsvc_pkg::ADDR_FB_DIV_LO: bus_rdata = feedback_divider[7:0];
			rsvc_pkg::ADDR_FB_DIV_MID: bus_rdata = feedback_divider[15:8];
			rsvc_pkg::ADDR_FB_DIV_HI: bus_rdata = {4'h0, feedback_divider[19:16]};
			rsvc_pkg::ADDR_STATUS: bus_rdata = {o_cal_busy, sel, crystal_osc_input_present, sec_present, pri_present};
			default: bus_rdata = 8'h00;
		endcase
	end

	// Input selection from live detector flags
	always_comb
	begin
		next_sel = rsvc_pkg::SEL_NONE;
		if (diff_mode)
		begin
			// Secondary pin is the complement here, so it never stands alone
			if (pri_present)
				next_sel = rsvc_pkg::SEL_PRIMARY;
			else if (!mode[1] && crystal_osc_input_present)
				next_sel = rsvc_pkg::SEL_CRYSTAL;
		end
		else
		begin
			case (mode)
				rsvc_pkg::MODE_REVERTIVE:
				begin
					if (i_force_secondary_pin && sec_present)
						next_sel = rsvc_pkg::SEL_SECONDARY;
					else if (pri_present)
						next_sel = rsvc_pkg::SEL_PRIMARY;
					else if (sec_present)
						next_sel = rsvc_pkg::SEL_SECONDARY;
					else if (crystal_osc_input_present)
						next_sel = rsvc_pkg::SEL_CRYSTAL;
				end
				rsvc_pkg::MODE_NONREVERTIVE:
				begin
					if (i_force_secondary_pin && sec_present)
						next_sel = rsvc_pkg::SEL_SECONDARY;
					else if (sel == rsvc_pkg::SEL_SECONDARY && sec_present)
						next_sel = rsvc_pkg::SEL_SECONDARY;
					else if (pri_present)
						next_sel = rsvc_pkg::SEL_PRIMARY;
					else if (sec_present)
						next_sel = rsvc_pkg::SEL_SECONDARY;
					else if (crystal_osc_input_present)
						next_sel = rsvc_pkg::SEL_CRYSTAL;
				end
				rsvc_pkg::MODE_MAN_PRIMARY:
				begin
					// No crystal fallback in manual modes
					if (i_force_secondary_pin && sec_present)
						next_sel = rsvc_pkg::SEL_SECONDARY;
					else if (pri_present)
						next_sel = rsvc_pkg::SEL_PRIMARY;
				end
				rsvc_pkg::MODE_MAN_SECONDARY:
				begin
					if (sec_present)
						next_sel = rsvc_pkg::SEL_SECONDARY;
				end
				default: next_sel = rsvc_pkg::SEL_NONE;
			endcase
		end
	end

	// Selector state and its registered outputs
	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
		begin
			sel <= rsvc_pkg::SEL_NONE;
			o_ref_select <= rsvc_pkg::SEL_NONE;
			o_holdover <= 1'b0;
			o_diff_input <= 1'b0;
		end
		else
		begin
			sel <= next_sel;
			o_ref_select <= next_sel;
			o_holdover <= (next_sel == rsvc_pkg::SEL_CRYSTAL);
			o_diff_input <= diff_mode;
		end
	end

	// Forced calibration needs the enable already set before the command write
	assign cal_kick = bus_wr && bus_addr == rsvc_pkg::ADDR_VCO_CAL && bus_wdata[rsvc_pkg::CAL_CMD_BIT]
		&& vco_calibration_control[rsvc_pkg::CAL_EN_BIT];

	// Calibration sequencer; reset itself starts a run
	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
		begin
			cal <= rsvc_pkg::CAL_RUN;
			cal_cnt <= 13'h0000;
		end
		else
		begin
			case (cal)
				rsvc_pkg::CAL_IDLE:
				begin
					cal_cnt <= 13'h0000;
					if (cal_kick)
						cal <= rsvc_pkg::CAL_RUN;
				end
				rsvc_pkg::CAL_RUN:
				begin
					// A new command mid-run restarts the full interval
					if (cal_kick)
						cal_cnt <= 13'h0000;
					else if (cal_cnt >= 13'(CAL_CYCLES - 1))
						cal <= rsvc_pkg::CAL_IDLE;
					else
						cal_cnt <= cal_cnt + 13'h0001;
				end
				default: cal <= rsvc_pkg::CAL_IDLE;
			endcase
		end
	end

	// Busy and static-output flags; band follows override or calibration result
	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
		begin
			o_cal_busy <= 1'b1;
			o_outputs_static <= 1'b1;
			o_vco_band <= 7'h00;
		end
		else
		begin
			o_cal_busy <= (cal == rsvc_pkg::CAL_RUN);
			o_outputs_static <= (cal == rsvc_pkg::CAL_RUN);
			if (vco_calibration_control[rsvc_pkg::BAND_EN_BIT])
				o_vco_band <= vco_band_override[7:1];
			else if (cal == rsvc_pkg::CAL_RUN)
				o_vco_band <= i_auto_band;
		end
	end

	// Crystal trim: source bit high keeps the 2 pF pin value
	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
			o_crystal_osc_input_cap_code <= rsvc_pkg::CRYSTAL_OSC_INPUT_CAP_PIN_CODE;
		else if (crystal_load_trim[rsvc_pkg::CRYSTAL_OSC_INPUT_SRC_BIT])
			o_crystal_osc_input_cap_code <= rsvc_pkg::CRYSTAL_OSC_INPUT_CAP_PIN_CODE;
		else
			o_crystal_osc_input_cap_code <= crystal_load_trim[5:0];
	end

	// Divider source chosen by its enable, clamped to the floor
	assign fb_src = reference_path_control[rsvc_pkg::FB_EN_BIT] ? feedback_divider : i_pin_fb_div;

	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
			o_fb_div <= rsvc_pkg::FB_DIV_MIN;
		else if (fb_src < rsvc_pkg::FB_DIV_MIN)
			o_fb_div <= rsvc_pkg::FB_DIV_MIN;
		else
			o_fb_div <= fb_src;
	end

	// Prescaler and doubler controls; prescaler sits ahead of the doubler
	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
		begin
			o_div5_primary <= 1'b0;
			o_x2_primary <= 1'b0;
			o_div5_secondary <= 1'b0;
			o_x2_secondary <= 1'b0;
		end
		else
		begin
			o_div5_primary <= reference_path_control[0];
			o_x2_primary <= reference_path_control[1];
			o_div5_secondary <= reference_path_control[2];
			o_x2_secondary <= reference_path_control[3];
		end
	end
endmodule : rsvc_top

// ### tb/rsvc_sva.sv
// Port-level checker for selection, calibration and register-side outputs
`timescale 1ns/1ps
module rsvc_sva #(
	parameter int CAL_CYCLES = 20,
	parameter int DET_TIMEOUT = 4
) (
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic [3:0] i_freq_sel_a,
	input wire logic [5:0] i_freq_sel_y,
	input wire logic i_sclk_om0,
	input wire logic i_csb_om1,
	input wire logic i_sdio_in_om2,
	input wire logic o_sdio_oe,
	input wire logic [2:0] o_out_mode_pins,
	input wire logic [3:0] o_ref_select,
	input wire logic o_holdover,
	input wire logic o_cal_busy,
	input wire logic o_outputs_static,
	input wire logic [5:0] o_crystal_osc_input_cap_code,
	input wire logic [19:0] o_fb_div
);
	localparam int CAL_MAX = CAL_CYCLES + 2;
	int busy_run;
	logic serial_off;
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_sys_rst);
	// Pins serve output mode unless a select group is all zero
	assign serial_off = (i_freq_sel_a != 4'h0) && (i_freq_sel_y != 6'h00);
	// Busy stretch length; slack of two covers the start-up edges
	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst || !o_cal_busy)
			busy_run <= 0;
		else
			busy_run <= busy_run + 1;
	end
	a_static_tracks_busy: assert property (o_outputs_static == o_cal_busy)
		else $error("output level not held while calibrating");
	a_cal_after_reset: assert property ($fell(i_sys_rst) |-> o_cal_busy [*8])
		else $error("no calibration after reset");
	a_cal_bounded: assert property (busy_run <= CAL_MAX)
		else $error("calibration runs too long");
	a_forced_cal_min: assert property ($rose(o_cal_busy) |-> o_cal_busy [*8])
		else $error("forced calibration cut short");
	a_holdover_flag: assert property (o_holdover == (o_ref_select == 4'h8))
		else $error("holdover flag disagrees with selection");
	a_select_onehot: assert property ($onehot(o_ref_select))
		else $error("selection not one-hot");
	a_cap_reset: assert property (disable iff (1'b0) i_sys_rst |=> o_crystal_osc_input_cap_code == 6'h08)
		else $error("crystal trim not at reset default");
	a_sel_reset: assert property (disable iff (1'b0) i_sys_rst |=> o_ref_select == 4'h1)
		else $error("selection not idle in reset");
	a_fb_div_floor: assert property (o_fb_div >= 20'h0_0020)
		else $error("feedback divider below floor");
	a_serial_quiet: assert property (serial_off [*3] |-> !o_sdio_oe)
		else $error("data pin driven outside serial mode");
	a_mode_pins: assert property (serial_off [*2] |=>
		o_out_mode_pins == $past({i_sdio_in_om2, i_csb_om1, i_sclk_om0}))
		else $error("output mode pins not captured");
	c_holdover: cover property (o_ref_select == 4'h8);
	c_secondary: cover property (o_ref_select == 4'h4);
	c_forced_cal: cover property ($rose(o_cal_busy));
endmodule : rsvc_sva

// ### tb/rsvc_refsrc.sv
// Reference, crystal and feedback-sample sources for the bench
`timescale 1ns/1ps
module rsvc_refsrc (
	input wire logic i_ref_clk,
	input wire logic [2:0] i_running,
	output logic o_fb_sample_en,
	output logic o_primary,
	output logic o_secondary,
	output logic o_crystal
);
	logic [1:0] phase;
	initial
	begin
		phase = 2'h0;
		o_fb_sample_en = 1'b0;
		{o_crystal, o_secondary, o_primary} = 3'h0;
	end
	// Sample every fourth cycle, toggle midway; a stopped source freezes so no edge is seen
	always @(posedge i_ref_clk)
	begin
		#1;
		phase = phase + 2'h1;
		o_fb_sample_en = (phase == 2'h0);
		if (phase == 2'h2)
			{o_crystal, o_secondary, o_primary} = {o_crystal, o_secondary, o_primary} ^ i_running;
	end
endmodule : rsvc_refsrc

// ### tb/rsvc_bench.sv
// Self-checking bench: serial register access, switchover, trim and calibration
`timescale 1ns/1ps
module rsvc_bench;
	logic clk, rst, fb_en, pri, sec, crystal_osc_input, force_sec, sclk, csb, sdi, sdio, sdo, sdo_oe, hold, diff, busy, stat;
	logic d5p, x2p, d5s, x2s;
	logic [3:0] fsel_a, sel;
	logic [5:0] fsel_y, cap;
	logic [2:0] om, running;
	logic [6:0] band;
	logic [19:0] fb_div;
	logic [7:0] rd;
	int failures, total_checks;
	logic [12:0] reg_addr [4] = '{13'h000e, 13'h0010, 13'h001b, 13'h0029};
	logic [7:0] reg_rst [4] = '{8'h00, 8'h00, 8'hbf, 8'h00};
	// Shared data wire: the device wins while it drives
	assign sdio = sdo_oe ? sdo : sdi;
	rsvc_top #(.CAL_CYCLES(20), .DET_TIMEOUT(4)) DUT (
		.i_ref_clk(clk), .i_sys_rst(rst), .i_fb_sample_en(fb_en), .i_primary_ref_input(pri),
		.i_secondary_ref_input(sec), .i_crystal_osc_input(crystal_osc_input), .i_force_secondary_pin(force_sec),
		.i_freq_sel_a(fsel_a), .i_freq_sel_y(fsel_y), .i_pin_fb_div(20'h0_0400), .i_auto_band(7'h55),
		.i_sclk_om0(sclk), .i_csb_om1(csb), .i_sdio_in_om2(sdio), .o_sdio_out(sdo), .o_sdio_oe(sdo_oe),
		.o_out_mode_pins(om), .o_ref_select(sel), .o_holdover(hold), .o_diff_input(diff),
		.o_cal_busy(busy), .o_outputs_static(stat), .o_vco_band(band), .o_crystal_osc_input_cap_code(cap),
		.o_fb_div(fb_div), .o_div5_primary(d5p), .o_x2_primary(x2p), .o_div5_secondary(d5s),
		.o_x2_secondary(x2s));
	rsvc_refsrc u_src (.i_ref_clk(clk), .i_running(running), .o_fb_sample_en(fb_en),
		.o_primary(pri), .o_secondary(sec), .o_crystal(crystal_osc_input));
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic print_verdict;
		if (failures == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict
	task automatic check(input logic [19:0] seen, input logic [19:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Inputs always move 1 ns after the rising edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	// One 24-bit frame; three cycles per clock phase keeps above the two-cycle minimum
	task automatic spi(input logic rnw, input logic [12:0] addr, input logic [7:0] wd, output logic [7:0] rdv);
		logic [23:0] frame;
		frame = {rnw, 2'h0, addr, wd};
		csb = 1'b0;
		for (int i = 23; i >= 0; i--)
		begin
			sclk = 1'b0;
			sdi = frame[i];
			tick(3);
			if (i < 8)
				rdv[i] = sdo;
			sclk = 1'b1;
			tick(3);
		end
		sclk = 1'b0;
		tick(3);
		csb = 1'b1;
		tick(4);
	endtask : spi
	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		logic [7:0] x;
		spi(1'b0, a, d, x);
	endtask : wr
	// Bounded wait on selection (0) or busy (1), then compare
	task automatic wait_for(input int which, input logic [3:0] exp);
		int n;
		n = 0;
		while (((which == 0) ? sel : {3'h0, busy}) !== exp && n < 200)
		begin
			tick(1);
			n++;
		end
		check((which == 0) ? sel : {3'h0, busy}, exp);
		// A used-up bound is a failure even if the value lands on the last try
		if (n == 200)
		begin
			failures++;
			print_verdict();
		end
	endtask : wait_for
	// Main sequence
	initial
	begin
		rst = 1'b1;
		running = 3'h7;
		force_sec = 1'b0;
		fsel_a = 4'h0;
		fsel_y = 6'h01;
		sclk = 1'b0;
		csb = 1'b1;
		sdi = 1'b0;
		failures = 0;
		total_checks = 0;
		tick(16);
		rst = 1'b0;
		check(busy, 1'b1);
		wait_for(1, 4'h0);
		check(band, 7'h55);
		check(cap, 6'h08);
		check(fb_div, 20'h0_0400);
		foreach (reg_addr[k])
		begin
			spi(1'b1, reg_addr[k], 8'h00, rd);
			check(rd, reg_rst[k]);
		end
		spi(1'b1, 13'h0005, 8'h00, rd);
		check(rd, 8'h00);
		wait_for(0, 4'h2);
		running = 3'h6;
		wait_for(0, 4'h4);
		running = 3'h7;
		wait_for(0, 4'h2);
		wr(13'h0029, 8'h40);
		running = 3'h6;
		wait_for(0, 4'h4);
		running = 3'h7;
		tick(60);
		check(sel, 4'h4);
		running = 3'h5;
		wait_for(0, 4'h2);
		running = 3'h4;
		wait_for(0, 4'h8);
		check(hold, 1'b1);
		running = 3'h0;
		wait_for(0, 4'h1);
		running = 3'h4;
		wait_for(0, 4'h8);
		running = 3'h7;
		wr(13'h0029, 8'h80);
		wait_for(0, 4'h2);
		force_sec = 1'b1;
		wait_for(0, 4'h4);
		running = 3'h5;
		wait_for(0, 4'h2);
		force_sec = 1'b0;
		running = 3'h4;
		wait_for(0, 4'h1);
		wr(13'h0029, 8'hc0);
		running = 3'h6;
		wait_for(0, 4'h4);
		running = 3'h7;
		wr(13'h0029, 8'h20);
		check(diff, 1'b1);
		force_sec = 1'b1;
		tick(60);
		check(sel, 4'h2);
		// Status: idle calibration, primary chosen, all three inputs seen
		spi(1'b1, 13'h002b, 8'h00, rd);
		check(rd, 8'h17);
		force_sec = 1'b0;
		wr(13'h001b, 8'h3f);
		check(cap, 6'h3f);
		wr(13'h001b, 8'h05);
		check(cap, 6'h05);
		wr(13'h0010, 8'hfe);
		check(band, 7'h55);
		wr(13'h000e, 8'h85);
		check(band, 7'h7f);
		check(busy, 1'b0);
		wr(13'h000e, 8'h85);
		check(busy, 1'b1);
		check(stat, 1'b1);
		wait_for(1, 4'h0);
		wr(13'h002a, 8'h1f);
		check({x2s, d5s, x2p, d5p}, 4'hf);
		wr(13'h0020, 8'h05);
		check(fb_div, 20'h0_0020);
		wr(13'h0021, 8'h01);
		wr(13'h0022, 8'h0f);
		check(fb_div, 20'hf_0105);
		fsel_a = 4'h1;
		csb = 1'b0;
		sclk = 1'b1;
		sdi = 1'b1;
		tick(3);
		check(om, 3'h5);
		wr(13'h001b, 8'h20);
		fsel_a = 4'h0;
		tick(3);
		check(cap, 6'h05);
		print_verdict();
	end
endmodule : rsvc_bench
bind rsvc_top rsvc_sva #(.CAL_CYCLES(CAL_CYCLES), .DET_TIMEOUT(DET_TIMEOUT)) u_sva (
	.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_freq_sel_a(i_freq_sel_a), .i_freq_sel_y(i_freq_sel_y),
	.i_sclk_om0(i_sclk_om0), .i_csb_om1(i_csb_om1), .i_sdio_in_om2(i_sdio_in_om2), .o_sdio_oe(o_sdio_oe),
	.o_out_mode_pins(o_out_mode_pins), .o_ref_select(o_ref_select), .o_holdover(o_holdover),
	.o_cal_busy(o_cal_busy), .o_outputs_static(o_outputs_static), .o_crystal_osc_input_cap_code(o_crystal_osc_input_cap_code),
	.o_fb_div(o_fb_div));
